/* logic/cte_alu.sv */
// combinational result and flag logic for the tail instructions
`timescale 1ns/1ps
module cte_alu (
   input  wire cte_pkg::cte_op_t   op,
   input  wire logic [7:0]         w,
   input  wire logic [7:0]         f,
   input  wire logic [7:0]         lit,
   input  wire logic               c_in,
   output logic      [7:0]         res,
   output cte_pkg::cte_flags_t     flg,
   output logic                    upd_c,
   output logic                    upd_z
);
   logic [7:0] minu;

   always_comb begin
      minu = (op == cte_pkg::CTE_OP_SUBL) ? lit : f;
      res = 8'h00;
      flg.c = c_in;
      flg.dc = 1'b0;
      flg.z = 1'b0;
      upd_c = 1'b0;
      upd_z = 1'b0;
      unique case (op)
         cte_pkg::CTE_OP_RRC: begin
            res = {c_in, f[7:1]}; // [RL4]
            flg.c = f[0]; // [RL4]
            upd_c = 1'b1;
         end
         cte_pkg::CTE_OP_SUBL, cte_pkg::CTE_OP_SUBR: begin
            res = minu - w; // [RL6] [RL7]
            flg.c = (w <= minu); // [RL8]
            flg.dc = (w[3:0] <= minu[3:0]); // [RL8]
            upd_c = 1'b1;
            upd_z = 1'b1;
         end
         cte_pkg::CTE_OP_XORR: begin
            res = w ^ f; // [RL9]
            upd_z = 1'b1;
         end
         cte_pkg::CTE_OP_XORL: begin
            res = w ^ lit; // [RL11]
            upd_z = 1'b1;
         end
         cte_pkg::CTE_OP_SWAP: begin
            res = {f[3:0], f[7:4]}; // [RL10]
         end
         default: begin
            res = 8'h00;
         end
      endcase
      flg.z = (res == 8'h00); // [RL12]
   end
endmodule

/* logic/cte_core.sv */
// instruction execute block with its AHB-Lite register slave
// Behaviour
// RL1: low-power op clears watchdog and its prescaler
// RL2: low-power op clears power-down, sets timeout flag
// RL3: low-power op halts oscillator until wake-up
// RL4: rotate right through carry, old carry to bit7
// RL5: select 0 writes W, 1 writes file register
// RL6: literal minus W into W, flags C DC Z
// RL7: file minus W routed by select, flags C DC Z
// RL8: carry means W not above minuend, nibble likewise
// RL9: W xor file routed by select, zero only
// RL10: nibble swap routed by select, flags unchanged
// RL11: W xor literal into W, zero only
// RL12: zero flag set when result is zero
// RL13: timeout and power-down stay readable after wake
`timescale 1ns/1ps
module cte_core (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        wake_pin,
   output logic             osc_halt,
   output logic             wdt_clear,
   output logic             wdt_prescale_clear,
   output logic             timeout_flag,
   output logic             power_down_flag
);
   typedef enum logic [1:0] {
      CTE_IDLE,
      CTE_FETCH,
      CTE_EXEC,
      CTE_ASLEEP
   } cte_state_t;
   // bus address phase capture
   logic        ap_vld_r, ap_vld_nxt;
   logic        ap_wr_r, ap_wr_nxt;
   logic [11:0] ap_addr_r, ap_addr_nxt;
   logic        rdw_r, rdw_nxt;
   // execute state
   cte_state_t          st_r, st_nxt;
   cte_pkg::cte_cmd_t   cmd_r, cmd_nxt;
   logic [7:0]          w_r, w_nxt;
   cte_pkg::cte_flags_t flg_r, flg_nxt;
   logic                to_r, to_nxt;
   logic                pd_r, pd_nxt;
   logic                wdtc_r, wdtc_nxt;
   // wake pin synchroniser
   logic wk_s1_r, wk_s2_r;
   logic                is_cmd, is_wreg, is_stat, is_wake, is_file;
   logic                dp_wr, dp_rd, cmd_take, bus_mem_rd, bus_mem_wr;
   logic                exec, ftype, wr_file, bus_own;
   logic [7:0]          mem_rdata, alu_res;
   logic [7:0]          mem_wdata;
   logic [6:0]          mem_addr;
   logic                mem_re, mem_we;
   cte_pkg::cte_flags_t alu_flg;
   logic                alu_upd_c, alu_upd_z;
   logic [6:0]          st_word;
   cte_file_mem #(
      .AW (cte_pkg::FADDR_W),
      .DW (cte_pkg::DATA_W)
   ) u_mem (
      .clk   (clk),
      .re    (mem_re),
      .we    (mem_we),
      .addr  (mem_addr),
      .wdata (mem_wdata),
      .rdata (mem_rdata)
   );
   cte_alu u_alu (
      .op    (cmd_r.op),
      .w     (w_r),
      .f     (mem_rdata),
      .lit   (cmd_r.lit),
      .c_in  (flg_r.c),
      .res   (alu_res),
      .flg   (alu_flg),
      .upd_c (alu_upd_c),
      .upd_z (alu_upd_z)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wk_s1_r <= 1'b0;
         wk_s2_r <= 1'b0;
      end else begin
         wk_s1_r <= wake_pin;
         wk_s2_r <= wk_s1_r;
      end
   end

   // decode of the access in its data phase
   always_comb begin
      is_cmd = (ap_addr_r == cte_pkg::OFS_CMD);
      is_wreg = (ap_addr_r == cte_pkg::OFS_WREG);
      is_stat = (ap_addr_r == cte_pkg::OFS_STATUS);
      is_wake = (ap_addr_r == cte_pkg::OFS_WAKE);
      is_file = ((ap_addr_r & cte_pkg::FILE_MASK) == cte_pkg::OFS_FILE);
      dp_wr = ap_vld_r & ap_wr_r;
      dp_rd = ap_vld_r & ~ap_wr_r;
      bus_own = (st_r == CTE_IDLE) || (st_r == CTE_ASLEEP);
      // instructions and file access wait while one executes
      hreadyout = 1'b1;
      if (ap_vld_r && (is_cmd || is_file) && !bus_own) begin
         hreadyout = 1'b0;
      end else if (dp_rd && is_file && !rdw_r) begin
         hreadyout = 1'b0;
      end
      // commands during sleep are dropped: only the idle state takes them
      cmd_take = dp_wr & is_cmd & (st_r == CTE_IDLE); // [RL3]
      bus_mem_rd = dp_rd & is_file & ~rdw_r & bus_own;
      bus_mem_wr = dp_wr & is_file & bus_own;
      hresp = 1'b0;
   end

   always_comb begin
      ap_vld_nxt = ap_vld_r;
      ap_wr_nxt = ap_wr_r;
      ap_addr_nxt = ap_addr_r;
      rdw_nxt = rdw_r;
      if (hreadyout) begin
         ap_vld_nxt = hsel & htrans[1] & hready;
         ap_wr_nxt = hwrite;
         ap_addr_nxt = {haddr[11:2], 2'b00};
         rdw_nxt = 1'b0;
      end else if (bus_mem_rd) begin
         rdw_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ap_vld_r <= 1'b0;
         ap_wr_r <= 1'b0;
         ap_addr_r <= 12'h000;
         rdw_r <= 1'b0;
      end else begin
         ap_vld_r <= ap_vld_nxt;
         ap_wr_r <= ap_wr_nxt;
         ap_addr_r <= ap_addr_nxt;
         rdw_r <= rdw_nxt;
      end
   end

   // memory port: the executing instruction owns it, else the bus
   always_comb begin
      exec = (st_r == CTE_EXEC);
      ftype = cmd_r.op inside {cte_pkg::CTE_OP_RRC, cte_pkg::CTE_OP_SUBR,
                               cte_pkg::CTE_OP_XORR, cte_pkg::CTE_OP_SWAP};
      wr_file = exec & ftype & cmd_r.dst_f; // [RL5]
      mem_re = (st_r == CTE_FETCH) | bus_mem_rd;
      mem_we = wr_file | bus_mem_wr;
      mem_addr = bus_own ? ap_addr_r[8:2] : cmd_r.faddr;
      mem_wdata = wr_file ? alu_res : hwdata[7:0];
   end

   always_comb begin
      st_nxt = st_r;
      cmd_nxt = cmd_r;
      w_nxt = w_r;
      flg_nxt = flg_r;
      to_nxt = to_r;
      pd_nxt = pd_r;
      wdtc_nxt = 1'b0;
      // software writes first so that an executing update wins
      if (dp_wr && is_wreg) begin
         w_nxt = hwdata[7:0];
      end
      if (dp_wr && is_stat) begin
         flg_nxt.c = hwdata[cte_pkg::ST_C];
         flg_nxt.dc = hwdata[cte_pkg::ST_DC];
         flg_nxt.z = hwdata[cte_pkg::ST_Z];
      end
      unique case (st_r)
         CTE_IDLE: begin
            if (cmd_take) begin
               cmd_nxt.op = cte_pkg::cte_op_t'(
                  hwdata[cte_pkg::CMD_OP_LSB +: 3]);
               cmd_nxt.dst_f = hwdata[cte_pkg::CMD_D_BIT];
               cmd_nxt.faddr = hwdata[cte_pkg::CMD_F_LSB +: 7];
               cmd_nxt.lit = hwdata[cte_pkg::CMD_K_LSB +: 8];
               st_nxt = CTE_FETCH;
            end
         end
         CTE_FETCH: begin
            st_nxt = CTE_EXEC;
         end
         CTE_EXEC: begin
            st_nxt = CTE_IDLE;
            if (cmd_r.op == cte_pkg::CTE_OP_SLEEP) begin
               wdtc_nxt = 1'b1; // [RL1]
               to_nxt = 1'b1; // [RL2]
               pd_nxt = 1'b0; // [RL2]
               st_nxt = CTE_ASLEEP; // [RL3]
            end else if (cmd_r.op != cte_pkg::CTE_OP_NOP) begin
               if (!(ftype && cmd_r.dst_f)) begin
                  w_nxt = alu_res; // [RL5] [RL6] [RL11]
               end
               if (alu_upd_c) begin
                  flg_nxt.c = alu_flg.c; // [RL4] [RL8]
               end
               if (alu_upd_z) begin
                  flg_nxt.z = alu_flg.z; // [RL12]
               end
               if (alu_upd_c && alu_upd_z) begin
                  flg_nxt.dc = alu_flg.dc; // [RL8]
               end
            end
         end
         CTE_ASLEEP: begin
            // wake keeps both flags so software can see why
            if (wk_s2_r || (dp_wr && is_wake && hwdata[0])) begin
               st_nxt = CTE_IDLE; // [RL13]
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= CTE_IDLE;
         cmd_r <= '{cte_pkg::CTE_OP_NOP, 1'b0, 7'h00, 8'h00};
         w_r <= cte_pkg::W_RST;
         flg_r <= '{c: 1'b0, dc: 1'b0, z: 1'b0};
         to_r <= cte_pkg::RST_TO;
         pd_r <= cte_pkg::RST_PD;
         wdtc_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cmd_r <= cmd_nxt;
         w_r <= w_nxt;
         flg_r <= flg_nxt;
         to_r <= to_nxt;
         pd_r <= pd_nxt;
         wdtc_r <= wdtc_nxt;
      end
   end

   always_comb begin
      st_word = {~bus_own, osc_halt, to_r, pd_r, flg_r.z, flg_r.dc, flg_r.c};
      hrdata = 32'h0000_0000;
      if (dp_rd) begin
         if (is_wreg) begin
            hrdata = {24'h00_0000, w_r};
         end else if (is_stat) begin
            hrdata = {25'h0, st_word}; // [RL13]
         end else if (is_cmd) begin
            hrdata = {8'h00, cmd_r.lit, 4'h0, 1'b0, cmd_r.faddr,
                      cmd_r.dst_f, cmd_r.op};
         end else if (is_file && rdw_r) begin
            hrdata = {24'h00_0000, mem_rdata};
         end
      end
   end

   assign osc_halt = (st_r == CTE_ASLEEP);
   assign wdt_clear = wdtc_r;
   assign wdt_prescale_clear = wdtc_r;
   assign timeout_flag = to_r;
   assign power_down_flag = pd_r;
   sequence s_sleep_exec;
      exec && cmd_r.op == cte_pkg::CTE_OP_SLEEP;
   endsequence
   sequence s_asleep_two;
      osc_halt [*2];
   endsequence
   property p_wdt_clr;
      @(posedge clk) disable iff (rst)
      s_sleep_exec |=> wdt_clear && wdt_prescale_clear ##1 !wdt_clear;
   endproperty
   a_wdt_clr: assert property (p_wdt_clr) // [RL1]
      else $error("watchdog not cleared by sleep");
   property p_sleep_flags;
      @(posedge clk) disable iff (rst)
      s_sleep_exec |=> timeout_flag && !power_down_flag
         && flg_r == $past(flg_r) && w_r == $past(w_r);
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) // [RL2]
      else $error("sleep flag update wrong");
   property p_sleep_halt;
      @(posedge clk) disable iff (rst)
      s_sleep_exec ##1 !wk_s2_r && !(dp_wr && is_wake) |-> s_asleep_two;
   endproperty
   a_sleep_halt: assert property (p_sleep_halt) // [RL3]
      else $error("oscillator not halted after sleep");
   property p_rrc;
      @(posedge clk) disable iff (rst)
      exec && cmd_r.op == cte_pkg::CTE_OP_RRC && !cmd_r.dst_f |=>
         w_r == {$past(flg_r.c), $past(mem_rdata[7:1])}
         && flg_r.c == $past(mem_rdata[0]);
   endproperty
   a_rrc: assert property (p_rrc) // [RL4]
      else $error("rotate through carry wrong");
   property p_dst_file;
      @(posedge clk) disable iff (rst)
      exec && ftype && cmd_r.dst_f |-> mem_we
         && mem_addr == cmd_r.faddr ##1 w_r == $past(w_r);
   endproperty
   a_dst_file: assert property (p_dst_file) // [RL5]
      else $error("file destination not written");
   property p_sub_carry;
      @(posedge clk) disable iff (rst)
      exec && cmd_r.op == cte_pkg::CTE_OP_SUBL |=>
         w_r == 8'($past(cmd_r.lit) - $past(w_r))
         && flg_r.c == ($past(w_r) <= $past(cmd_r.lit));
   endproperty
   a_sub_carry: assert property (p_sub_carry) // [RL6] [RL8]
      else $error("literal subtract wrong");
   property p_swap_flags;
      @(posedge clk) disable iff (rst)
      exec && cmd_r.op == cte_pkg::CTE_OP_SWAP && !dp_wr |=>
         flg_r == $past(flg_r);
   endproperty
   a_swap_flags: assert property (p_swap_flags) // [RL10]
      else $error("swap changed flags");
   property p_zero;
      @(posedge clk) disable iff (rst)
      exec && alu_upd_z |=> flg_r.z == ($past(alu_res) == 8'h00);
   endproperty
   a_zero: assert property (p_zero) // [RL12]
      else $error("zero flag wrong");
   property p_wake_keep;
      @(posedge clk) disable iff (rst)
      osc_halt ##1 !osc_halt |-> $stable(timeout_flag)
         && $stable(power_down_flag);
   endproperty
   a_wake_keep: assert property (p_wake_keep) // [RL13]
      else $error("wake changed timeout or power-down");
endmodule

/* logic/cte_file_mem.sv */
// file register memory with registered read data
`timescale 1ns/1ps
module cte_file_mem #(
   parameter int AW = 7,
   parameter int DW = 8
) (
   input  wire logic          clk,
   input  wire logic          re,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] mem [2**AW];

   // no reset on the array: contents are unknown until written
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      if (re) begin
         rdata <= mem[addr];
      end
   end
endmodule

/* logic/cte_pkg.sv */
// shared constants and types for the tail instruction execute block
package cte_pkg;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   // register byte offsets
   localparam logic [11:0] OFS_CMD = 12'h000;
   localparam logic [11:0] OFS_WREG = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_WAKE = 12'h00c;
   localparam logic [11:0] OFS_FILE = 12'h200;
   localparam logic [11:0] FILE_MASK = 12'he00;
   // command word fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_D_BIT = 3;
   localparam int CMD_F_LSB = 4;
   localparam int CMD_K_LSB = 16;
   // status word fields
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_PD = 3;
   localparam int ST_TO = 4;
   localparam int ST_SLEEP = 5;
   localparam int ST_BUSY = 6;
   // values after reset
   localparam logic [7:0] W_RST = 8'h00;
   localparam logic RST_TO = 1'b1;
   localparam logic RST_PD = 1'b1;
   localparam logic [7:0] WDT_ZERO = 8'h00;

   typedef enum logic [2:0] {
      CTE_OP_SLEEP = 3'h0,
      CTE_OP_RRC = 3'h1,
      CTE_OP_SUBL = 3'h2,
      CTE_OP_SUBR = 3'h3,
      CTE_OP_XORR = 3'h4,
      CTE_OP_SWAP = 3'h5,
      CTE_OP_XORL = 3'h6,
      CTE_OP_NOP = 3'h7
   } cte_op_t;

   typedef struct packed {
      cte_op_t op;
      logic dst_f;
      logic [6:0] faddr;
      logic [7:0] lit;
   } cte_cmd_t;

   typedef struct packed {
      logic c;
      logic dc;
      logic z;
   } cte_flags_t;
endpackage

/* testbench/cte_core_tb.sv */
// self-checking bench for the tail instruction execute block
`timescale 1ns/1ps
module cte_core_tb;
   logic        clk;
   logic        rst;
   logic        hsel;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        wake_pin;
   logic        osc_halt;
   logic        wdt_clear;
   logic        wdt_prescale_clear;
   logic        timeout_flag;
   logic        power_down_flag;
   int          error_cnt;
   int          checks;
   int          pulse_a;
   int          pulse_b;
   logic [31:0] w_got;
   logic [31:0] f_got;
   logic [31:0] st_got;

   // single slave, so its ready is the bus ready; hsize fixed to word
   cte_core dut_u (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .wake_pin(wake_pin), .osc_halt(osc_halt), .wdt_clear(wdt_clear),
      .wdt_prescale_clear(wdt_prescale_clear),
      .timeout_flag(timeout_flag), .power_down_flag(power_down_flag));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // counts watchdog pulses, and pulses where both clears coincide
   always @(posedge clk) begin
      if (wdt_clear === 1'b1)
         pulse_a++;
      if (wdt_clear === 1'b1 && wdt_prescale_clear === 1'b1)
         pulse_b++;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one single transfer; waits on ready, a hang is left to the watchdog
   task automatic xfer(input logic [11:0] a, input logic wr,
                       input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
      // address and data edges plus two busy cycles and one file wait at most
      chk("ready wait", 32'h0, {31'h0, n > 5});
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      xfer(a, 1'b1, d, dummy);
   endtask

   task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
      xfer(a, 1'b0, 32'h0, d);
   endtask

   task automatic run_op(input cte_pkg::cte_op_t op, input logic d,
         input logic [6:0] f, input logic [7:0] k, input logic [7:0] w,
         input logic [7:0] fv, input logic [2:0] st);
      logic [11:0] fa;
      fa = cte_pkg::OFS_FILE + {3'h0, f, 2'h0};
      wr_reg(cte_pkg::OFS_WREG, {24'h0, w});
      wr_reg(fa, {24'h0, fv});
      wr_reg(cte_pkg::OFS_STATUS, {29'h0, st});
      wr_reg(cte_pkg::OFS_CMD, {8'h0, k, 5'h0, f, d, op});
      // file access stalls until the op retires, so W read after is fresh
      rd_reg(fa, f_got);
      rd_reg(cte_pkg::OFS_WREG, w_got);
      rd_reg(cte_pkg::OFS_STATUS, st_got);
   endtask

   // st is {zero, digit carry, carry}
   task automatic expect_op(input logic d, input logic [7:0] res,
         input logic [7:0] w, input logic [7:0] fv, input logic [2:0] st);
      chk("wreg", {24'h0, d ? w : res}, w_got);
      chk("file", {24'h0, d ? res : fv}, f_got);
      chk("flags", {29'h0, st}, {29'h0, st_got[2:0]});
   endtask

   task automatic t_reset;
      chk("timeout", 32'h1, {31'h0, timeout_flag});
      chk("power down", 32'h1, {31'h0, power_down_flag});
      chk("osc halt", 32'h0, {31'h0, osc_halt});
      rd_reg(cte_pkg::OFS_STATUS, st_got);
      chk("status", 32'h18, {26'h0, st_got[5:0]});
      $display("test reset done");
   endtask

   task automatic t_sub;
      logic [7:0] m [4] = '{8'h05, 8'h05, 8'h20, 8'h00};
      logic [7:0] w [4] = '{8'h05, 8'h06, 8'h1f, 8'hff};
      logic [7:0] r;
      logic [2:0] s;
      for (int i = 0; i < 4; i++) begin
         r = m[i] - w[i];
         s = {r == 8'h0, w[i][3:0] <= m[i][3:0], w[i] <= m[i]};
         run_op(cte_pkg::CTE_OP_SUBL, 1'b0, 7'h10, m[i], w[i], 8'h0, 3'h0);
         expect_op(1'b0, r, w[i], 8'h0, s);
         run_op(cte_pkg::CTE_OP_SUBR, i[0], 7'h7f, 8'h0, w[i], m[i], 3'h7);
         expect_op(i[0], r, w[i], m[i], s);
      end
      $display("test subtract done");
   endtask

   task automatic t_rot;
      logic [7:0] fv [2] = '{8'h01, 8'h80};
      for (int i = 0; i < 2; i++) begin
         run_op(cte_pkg::CTE_OP_RRC, i[0], 7'h00, 8'h0, 8'h33, fv[i],
                {2'h3, i[0]});
         expect_op(i[0], {i[0], fv[i][7:1]}, 8'h33, fv[i],
                   {2'h3, fv[i][0]});
      end
      $display("test rotate done");
   endtask

   task automatic t_xor_swap;
      run_op(cte_pkg::CTE_OP_XORR, 1'b1, 7'h05, 8'h0, 8'h5a, 8'h5a, 3'h3);
      expect_op(1'b1, 8'h00, 8'h5a, 8'h5a, 3'h7);
      run_op(cte_pkg::CTE_OP_XORR, 1'b0, 7'h06, 8'h0, 8'h3c, 8'hc3, 3'h4);
      expect_op(1'b0, 8'hff, 8'h3c, 8'hc3, 3'h0);
      run_op(cte_pkg::CTE_OP_XORL, 1'b0, 7'h01, 8'hf0, 8'h0f, 8'h11, 3'h7);
      expect_op(1'b0, 8'hff, 8'h0f, 8'h11, 3'h3);
      run_op(cte_pkg::CTE_OP_SWAP, 1'b0, 7'h22, 8'h0, 8'h44, 8'h3c, 3'h5);
      expect_op(1'b0, 8'hc3, 8'h44, 8'h3c, 3'h5);
      run_op(cte_pkg::CTE_OP_SWAP, 1'b1, 7'h23, 8'h0, 8'h44, 8'h00, 3'h2);
      expect_op(1'b1, 8'h00, 8'h44, 8'h00, 3'h2);
      // code 7 must leave W, the file register and the flags alone
      run_op(cte_pkg::CTE_OP_NOP, 1'b1, 7'h24, 8'h5a, 8'h99, 8'h66, 3'h6);
      expect_op(1'b1, 8'h66, 8'h99, 8'h66, 3'h6);
      $display("test xor and swap done");
   endtask

   task automatic t_sleep;
      int n;
      chk("no clear before sleep", 32'h0, pulse_a);
      wr_reg(cte_pkg::OFS_WREG, 32'h77);
      wr_reg(cte_pkg::OFS_CMD, 32'h0);
      repeat (6) @(posedge clk);
      chk("wdt clear pulses", 32'h1, pulse_a);
      chk("prescale clear pulses", 32'h1, pulse_b);
      chk("timeout", 32'h1, {31'h0, timeout_flag});
      chk("power down", 32'h0, {31'h0, power_down_flag});
      chk("osc halt", 32'h1, {31'h0, osc_halt});
      rd_reg(cte_pkg::OFS_STATUS, st_got);
      chk("asleep status", 32'h30, {26'h0, st_got[5:3], 3'h0});
      // an instruction issued while asleep must not run
      wr_reg(cte_pkg::OFS_CMD, {8'h0, 8'hff, 13'h0, 3'h6});
      repeat (4) @(posedge clk);
      rd_reg(cte_pkg::OFS_WREG, w_got);
      chk("wreg asleep", 32'h77, w_got);
      wake_pin <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (osc_halt !== 1'b0 && n < 10);
      wake_pin <= 1'b0;
      chk("osc halt woken", 32'h0, {31'h0, osc_halt});
      chk("timeout woken", 32'h1, {31'h0, timeout_flag});
      chk("pd woken", 32'h0, {31'h0, power_down_flag});
      wr_reg(cte_pkg::OFS_CMD, {8'h0, 8'hff, 13'h0, 3'h6});
      rd_reg(cte_pkg::OFS_FILE, f_got);
      rd_reg(cte_pkg::OFS_WREG, w_got);
      chk("wreg after wake", 32'h88, w_got);
      // second sleep, ended by the wake register instead of the pin
      wr_reg(cte_pkg::OFS_CMD, 32'h0);
      repeat (6) @(posedge clk);
      chk("asleep again", 32'h1, {31'h0, osc_halt});
      chk("wdt clear pulses", 32'h2, pulse_a);
      chk("prescale clear pulses", 32'h2, pulse_b);
      wr_reg(cte_pkg::OFS_WAKE, 32'h1);
      @(posedge clk);
      chk("osc halt reg wake", 32'h0, {31'h0, osc_halt});
      chk("timeout reg wake", 32'h1, {31'h0, timeout_flag});
      chk("pd reg wake", 32'h0, {31'h0, power_down_flag});
      $display("test sleep done");
   endtask

   initial begin
      #2000000;
      $display("watchdog expired");
      error_cnt++;
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 12'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      wake_pin = 1'b0;
      error_cnt = 0;
      checks = 0;
      pulse_a = 0;
      pulse_b = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_sub();
      t_rot();
      t_xor_swap();
      t_sleep();
      print_verdict();
   end
endmodule
